// ---- hdl/dtwm_defines.vh ----
// constants for the two-wire diagnostics memory slave
// assumes a single 50 MHz clock and an 8-bit byte-wide map
//
// What this block does
// (RULE_01) host alone drives serial clock line
// (RULE_02) rising clock samples data; protected bytes unwritten
// (RULE_03) read data changes on falling clock edges
// (RULE_04) data line shared, open drain both ways
// (RULE_05) host frames transfers with start, stop
// (RULE_06) memory holds 8-bit words, single or run
// (RULE_07) random and sequential access from address zero
// (RULE_08) rate bit one selects fibre channel mode
// (RULE_09) rate bit zero selects standard 10G mode
// (RULE_10) reset clears rate bit to 10G
// (RULE_11) live monitor values readable by host
// (RULE_12) alarm and warning flags on range exit
// (RULE_13) byte address advances after each byte
`ifndef DTWM_DEFINES_VH
`define DTWM_DEFINES_VH
// ==========================================
// bus address and map layout
`define DTWM_DEV_ADDR 7'h50
`define DTWM_ADDR_W 8
`define DTWM_OFS_TEMP 8'h60
`define DTWM_OFS_BIAS 8'h64
`define DTWM_OFS_TXPWR 8'h66
`define DTWM_OFS_RXPWR 8'h68
`define DTWM_OFS_VCC 8'h6A
`define DTWM_OFS_ALARM 8'h50
`define DTWM_OFS_WARN 8'h52
`define DTWM_OFS_RATE 8'h75
`define DTWM_RATE_BIT 0
`define DTWM_RATE_RESET 8'h00
`define DTWM_WP_LIMIT 8'h7F
`endif

// ---- hdl/dtwm_slave.v ----
// two-wire serial slave giving byte access to a diagnostics memory map
// assumes scl and sda come from pins outside the mclk domain;
// monitor values and range limits arrive as parallel inputs
// the host must hold each scl half period for at least 8 mclk cycles,
// since the pin filters add up to four cycles of delay to every edge
`timescale 1ns/1ps
`include "dtwm_defines.vh"
module dtwm_slave #(
  parameter DEPTH = 256
) (
  input wire mclk,
  input wire sys_rst,
  input wire clkEn,
  input wire sclIn,
  input wire sdaIn,
  output reg sdaOut,
  output reg sdaOe_n,
  input wire [15:0] monTemp,
  input wire [15:0] monBias,
  input wire [15:0] monTxPwr,
  input wire [15:0] monRxPwr,
  input wire [15:0] monVcc,
  input wire [4:0] limAlarmHi,
  input wire [4:0] limAlarmLo,
  input wire [4:0] limWarnHi,
  input wire [4:0] limWarnLo,
  output reg fibre_channel_8g_mode,
  output reg busy
);
  // protocol states: address byte, acknowledge, word address, write data,
  // write acknowledge, read data and the host's acknowledge of a read byte;
  // a start or a stop seen on the filtered lines overrides every state, so a
  // cut frame always returns the engine to a known place
  localparam ST_IDLE = 3'h0;
  localparam ST_DEVADR = 3'h1;
  localparam ST_ACKDEV = 3'h2;
  localparam ST_WADDR = 3'h3;
  localparam ST_WDATA = 3'h4;
  localparam ST_ACKW = 3'h5;
  localparam ST_RDATA = 3'h6;
  localparam ST_RACK = 3'h7;

  // ==========================================
  // pin synchronisers, three stages each
  // the first stage may go metastable and is read only by the second;
  // a level is taken once the second and third stages agree, which also
  // rejects single-cycle glitches on the open-drain lines
  reg [2:0] sclSync;
  reg [2:0] sdaSync;
  reg sclState;
  reg sdaState;
  always @(posedge mclk) begin
    if (sys_rst) begin
      sclSync <= 3'h7;
      sdaSync <= 3'h7;
      sclState <= 1'b1;
      sdaState <= 1'b1;
    end else if (clkEn) begin
      sclSync <= {sclSync[1:0], sclIn};
      sdaSync <= {sdaSync[1:0], sdaIn};
      if (sclSync[1] == sclSync[2])
        sclState <= sclSync[2];
      if (sdaSync[1] == sdaSync[2])
        sdaState <= sdaSync[2];
    end
  end

  // edges of the filtered line levels; host owns the clock line
  // start and stop are data moves while the clock stands high
  wire sclHigh = sclSync[1] & sclSync[2];
  wire sclLow = ~sclSync[1] & ~sclSync[2];
  wire sclRise = ~sclState & sclHigh; // RULE_01
  wire sclFall = sclState & sclLow;
  wire sdaHigh = sdaSync[1] & sdaSync[2];
  wire sdaLow = ~sdaSync[1] & ~sdaSync[2];
  wire startCond = sclState & sclHigh & sdaState & sdaLow; // RULE_05
  wire stopCond = sclState & sclHigh & ~sdaState & sdaHigh; // RULE_05

  // ==========================================
  // memory, flip-flop storage indexed by byte address
  reg [7:0] mem [0:DEPTH-1]; // RULE_06
  // flag registers are read by the read-data function below, so they are
  // declared ahead of it
  reg [4:0] alarmFlags;
  reg [4:0] warnFlags;

  // writable only above the protection limit, plus the rate byte
  function wrAllowed;
    input [7:0] a;
    begin
      wrAllowed = (a > `DTWM_WP_LIMIT) || (a == `DTWM_OFS_RATE); // RULE_02
    end
  endfunction

  // flag for one monitored value: set when its high or low limit input is set
  function rangeFlag;
    input [15:0] v;
    input hiLim;
    input loLim;
    begin
      rangeFlag = hiLim | loLim;
    end
  endfunction

  // read data: live monitors, flags, or stored bytes
  // monitors are sampled as the first bit of a byte is launched, so a
  // sixteen-bit value read in one run may straddle an update
  function [7:0] readByte;
    input [7:0] a;
    reg [7:0] m;
    begin
      m = mem[a];
      case (a)
        `DTWM_OFS_TEMP: readByte = monTemp[15:8]; // RULE_11
        `DTWM_OFS_TEMP + 8'h01: readByte = monTemp[7:0];
        `DTWM_OFS_BIAS: readByte = monBias[15:8];
        `DTWM_OFS_BIAS + 8'h01: readByte = monBias[7:0];
        `DTWM_OFS_TXPWR: readByte = monTxPwr[15:8];
        `DTWM_OFS_TXPWR + 8'h01: readByte = monTxPwr[7:0];
        `DTWM_OFS_RXPWR: readByte = monRxPwr[15:8];
        `DTWM_OFS_RXPWR + 8'h01: readByte = monRxPwr[7:0];
        `DTWM_OFS_VCC: readByte = monVcc[15:8];
        `DTWM_OFS_VCC + 8'h01: readByte = monVcc[7:0];
        `DTWM_OFS_ALARM: readByte = {3'h0, alarmFlags}; // RULE_12
        `DTWM_OFS_WARN: readByte = {3'h0, warnFlags}; // RULE_12
        default: readByte = m;
      endcase
    end
  endfunction

  // ==========================================
  // alarm and warning flags, one bit per monitored value
  // flags follow the limit inputs each cycle, they are not sticky
  always @(posedge mclk) begin
    if (sys_rst) begin
      alarmFlags <= 5'h00;
      warnFlags <= 5'h00;
    end else if (clkEn) begin
      alarmFlags <= {rangeFlag(monTemp, limAlarmHi[4], limAlarmLo[4]),
                     rangeFlag(monBias, limAlarmHi[3], limAlarmLo[3]),
                     rangeFlag(monTxPwr, limAlarmHi[2], limAlarmLo[2]),
                     rangeFlag(monRxPwr, limAlarmHi[1], limAlarmLo[1]),
                     rangeFlag(monVcc, limAlarmHi[0], limAlarmLo[0])}; // RULE_12
      warnFlags <= {rangeFlag(monTemp, limWarnHi[4], limWarnLo[4]),
                    rangeFlag(monBias, limWarnHi[3], limWarnLo[3]),
                    rangeFlag(monTxPwr, limWarnHi[2], limWarnLo[2]),
                    rangeFlag(monRxPwr, limWarnHi[1], limWarnLo[1]),
                    rangeFlag(monVcc, limWarnHi[0], limWarnLo[0])}; // RULE_12
    end
  end

  // ==========================================
  // protocol engine
  reg [2:0] state;
  reg [2:0] bitCnt;
  reg [7:0] shiftReg;
  reg [7:0] addrPtr;
  reg readMode;
  reg addrPending;
  // set on the eighth rising clock of a byte; a flag rather than a test of
  // the shift register, so that a data byte of zero still completes and a
  // leftover value never completes a byte early after a start
  reg byteFull;
  integer i;

  // next byte to send, looked up once at the current pointer
  wire [7:0] rdNext;
  assign rdNext = readByte(addrPtr);

  always @(posedge mclk) begin
    if (sys_rst) begin
      state <= ST_IDLE;
      bitCnt <= 3'h0;
      shiftReg <= 8'h00;
      addrPtr <= 8'h00; // RULE_07
      readMode <= 1'b0;
      addrPending <= 1'b0;
      byteFull <= 1'b0;
      sdaOut <= 1'b1;
      sdaOe_n <= 1'b1;
      busy <= 1'b0;
      fibre_channel_8g_mode <= 1'b0; // RULE_10
      for (i = 0; i < DEPTH; i = i + 1)
        mem[i] <= 8'h00;
      mem[`DTWM_OFS_RATE] <= `DTWM_RATE_RESET; // RULE_10
    end else if (clkEn) begin
      // rate bit steers clock recovery mode
      fibre_channel_8g_mode <= mem[`DTWM_OFS_RATE][`DTWM_RATE_BIT]; // RULE_08 RULE_09
      if (startCond) begin
        // a start, repeated or not, always restarts the address byte
        state <= ST_DEVADR;
        bitCnt <= 3'h0;
        byteFull <= 1'b0;
        busy <= 1'b1;
        sdaOe_n <= 1'b1;
      end else if (stopCond) begin
        state <= ST_IDLE;
        busy <= 1'b0;
        sdaOe_n <= 1'b1;
      end else begin
        case (state)
          ST_IDLE: begin
            sdaOe_n <= 1'b1;
          end
          ST_DEVADR, ST_WADDR, ST_WDATA: begin
            if (sclRise) begin
              // bits arrive most significant first
              shiftReg <= {shiftReg[6:0], sdaState}; // RULE_02
              bitCnt <= bitCnt + 3'h1;
              if (bitCnt == 3'h7)
                byteFull <= 1'b1;
            end else if (sclFall && byteFull) begin
              // eighth bit done: decide acknowledge on falling edge
              if (state == ST_DEVADR) begin
                if (shiftReg[7:1] == `DTWM_DEV_ADDR) begin
                  readMode <= shiftReg[0];
                  sdaOut <= 1'b0;
                  sdaOe_n <= 1'b0; // RULE_04
                  state <= ST_ACKDEV;
                end else begin
                  state <= ST_IDLE;
                  busy <= 1'b0;
                end
              end else if (state == ST_WADDR) begin
                addrPtr <= shiftReg; // RULE_07
                sdaOut <= 1'b0;
                sdaOe_n <= 1'b0;
                state <= ST_ACKW;
              end else begin
                if (wrAllowed(addrPtr))
                  mem[addrPtr] <= shiftReg; // RULE_02
                addrPtr <= addrPtr + 8'h01; // RULE_13
                sdaOut <= 1'b0;
                sdaOe_n <= 1'b0;
                state <= ST_ACKW;
              end
              byteFull <= 1'b0;
              shiftReg <= 8'h00;
            end
          end
          // acknowledge bit stands until the next falling clock
          ST_ACKDEV: begin
            if (sclFall) begin
              if (readMode) begin
                shiftReg <= rdNext;
                sdaOut <= rdNext[7];
                sdaOe_n <= rdNext[7]; // RULE_03 RULE_04
                bitCnt <= 3'h0;
                state <= ST_RDATA;
              end else begin
                sdaOe_n <= 1'b1;
                addrPending <= 1'b1;
                shiftReg <= 8'h01;
                bitCnt <= 3'h0;
                state <= ST_WADDR;
              end
            end
          end
          ST_ACKW: begin
            if (sclFall) begin
              sdaOe_n <= 1'b1;
              shiftReg <= 8'h01;
              bitCnt <= 3'h0;
              addrPending <= 1'b0;
              state <= ST_WDATA;
            end
          end
          // open drain: a one is sent by releasing the line to its pull-up
          ST_RDATA: begin
            if (sclFall) begin
              if (bitCnt == 3'h7) begin
                sdaOe_n <= 1'b1;
                addrPtr <= addrPtr + 8'h01; // RULE_13
                state <= ST_RACK;
              end else begin
                sdaOut <= shiftReg[6];
                sdaOe_n <= shiftReg[6]; // RULE_03
                shiftReg <= {shiftReg[6:0], 1'b0};
                bitCnt <= bitCnt + 3'h1;
              end
            end
          end
          // host acknowledge asks for another byte, no acknowledge ends the run
          ST_RACK: begin
            if (sclRise) begin
              readMode <= ~sdaState;
            end else if (sclFall) begin
              if (readMode) begin
                shiftReg <= rdNext;
                sdaOut <= rdNext[7];
                sdaOe_n <= rdNext[7]; // RULE_03
                bitCnt <= 3'h0;
                state <= ST_RDATA;
              end else begin
                state <= ST_IDLE;
              end
            end
          end
          default: begin
            state <= ST_IDLE;
          end
        endcase
      end
    end
  end
endmodule // dtwm_slave

// ---- test/dtwm_slave_properties.sv ----
// checker on the ports of the two-wire slave
// assumes bind into dtwm_slave; sdaIn is the resolved wire level
`timescale 1ns/1ps
module dtwm_slave_properties (
  input wire mclk,
  input wire sys_rst,
  input wire clkEn,
  input wire sclIn,
  input wire sdaIn,
  input wire sdaOut,
  input wire sdaOe_n,
  input wire fibre_channel_8g_mode,
  input wire busy
);
  // ==========================================
  // port relations
  default clocking dc @(posedge mclk); endclocking
  default disable iff (sys_rst);
  property p_zero; !sdaOe_n |-> !sdaOut; endproperty
  a_zero: assert property (p_zero) else $error("sda driven high");
  property p_rst_mode; disable iff (1'b0)
    sys_rst && clkEn |=> !fibre_channel_8g_mode; endproperty
  a_rst_mode: assert property (p_rst_mode) else $error("mode not cleared");
  property p_rst_idle; disable iff (1'b0)
    sys_rst && clkEn |=> sdaOe_n && !busy; endproperty
  a_rst_idle: assert property (p_rst_idle) else $error("not idle in reset");
  property p_out_low; $changed(sdaOe_n) |-> !sclIn; endproperty
  a_out_low: assert property (p_out_low) else $error("sda moved, clock high");
  property p_mode_low; $changed(fibre_channel_8g_mode) |-> !sclIn; endproperty
  a_mode_low: assert property (p_mode_low) else $error("mode moved, clock high");
  property p_idle; !busy |-> sdaOe_n; endproperty
  a_idle: assert property (p_idle) else $error("drive while idle");
  property p_start; $rose(busy) |-> sclIn && !sdaIn; endproperty
  a_start: assert property (p_start) else $error("busy without start");
  property p_stop; busy && sclIn && $rose(sdaIn) |-> ##[1:8] !busy; endproperty
  a_stop: assert property (p_stop) else $error("stop not seen");
endmodule // dtwm_slave_properties
bind dtwm_slave dtwm_slave_properties i_props (.mclk(mclk), .sys_rst(sys_rst),
  .clkEn(clkEn), .sclIn(sclIn), .sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOe_n(sdaOe_n),
  .fibre_channel_8g_mode(fibre_channel_8g_mode), .busy(busy));

// ---- test/dtwm_host_model.sv ----
// host side of the two-wire link: clock source and open-drain data pull
// assumes a pull-up on sda; scl idles high between frames
`timescale 1ns/1ps
module dtwm_host_model (
  input wire mclk,
  input wire sdaWire,
  output reg sclOut,
  output reg sdaPull
);
  // ==========================================
  // line idle and timing
  initial begin
    sclOut = 1'b1;
    sdaPull = 1'b0;
  end
  task half; repeat (8) @(posedge mclk); endtask
  // one bit: data set while clock low, sampled at end of high
  task bitx(input logic o, output logic i);
    repeat (2) @(posedge mclk);
    sdaPull <= ~o;
    half;
    sclOut <= 1'b1;
    half;
    i = sdaWire;
    sclOut <= 1'b0;
  endtask
  // start or repeated start: data falls while clock high
  task start;
    repeat (2) @(posedge mclk);
    sdaPull <= 1'b0;
    half;
    sclOut <= 1'b1;
    half;
    sdaPull <= 1'b1;
    half;
    sclOut <= 1'b0;
  endtask
  task stop;
    repeat (2) @(posedge mclk);
    sdaPull <= 1'b1;
    half;
    sclOut <= 1'b1;
    half;
    sdaPull <= 1'b0;
    half;
  endtask
  task wbyte(input logic [7:0] d, output logic ack);
    logic x;
    for (int k = 7; k >= 0; k--) bitx(d[k], x);
    bitx(1'b1, x);
    ack = ~x;
  endtask
  // last byte answered with no-ack, others with ack
  task rbyte(input logic last, output logic [7:0] d);
    logic x;
    for (int k = 7; k >= 0; k--) bitx(1'b1, d[k]);
    bitx(last, x);
  endtask
endmodule // dtwm_host_model

// ---- test/dtwm_slave_bench.sv ----
// self-checking bench for the two-wire diagnostics slave
// assumes dtwm_host_model as the host and a pull-up on sda
`timescale 1ns/1ps
module dtwm_slave_bench;
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic [79:0] monAll = 80'h0;
  logic [19:0] limAll = 20'h0;
  logic [7:0] lastByte;
  wire sclW, sdaPull, sdaOut, sdaOe_n, fcMode, busy;
  wire sdaW = (sdaOe_n | sdaOut) & ~sdaPull; // wired-and with pull-up
  int err_total = 0;
  int cmp_count = 0;
  always #10 mclk = ~mclk;
  dtwm_slave i_dtwm_slave (.mclk(mclk), .sys_rst(sys_rst), .clkEn(1'b1), .sclIn(sclW),
    .sdaIn(sdaW), .sdaOut(sdaOut), .sdaOe_n(sdaOe_n), .monTemp(monAll[79:64]),
    .monBias(monAll[63:48]), .monTxPwr(monAll[47:32]), .monRxPwr(monAll[31:16]),
    .monVcc(monAll[15:0]), .limAlarmHi(limAll[19:15]), .limAlarmLo(limAll[14:10]),
    .limWarnHi(limAll[9:5]), .limWarnLo(limAll[4:0]), .fibre_channel_8g_mode(fcMode),
    .busy(busy));
  dtwm_host_model i_dtwm_host_model (.mclk(mclk), .sdaWire(sdaW), .sclOut(sclW),
    .sdaPull(sdaPull));
  // ==========================================
  // compare and transfer helpers
  task chk_byte(input string n, input logic [7:0] e, input logic [7:0] g);
    cmp_count++;
    if (g !== e) begin
      err_total++;
      $display("unexpected %s: expected %h seen %h", n, e, g);
    end
  endtask
  task chk_bit(input string n, input logic e, input logic g);
    chk_byte(n, {7'h00, e}, {7'h00, g});
  endtask
  task send(input logic [7:0] d);
    logic a;
    i_dtwm_host_model.wbyte(d, a);
    chk_bit("ack", 1'b1, a);
  endtask
  task wr(input logic [7:0] a, input logic [7:0] q[$]);
    i_dtwm_host_model.start;
    send(8'hA0);
    send(a);
    foreach (q[i]) send(q[i]);
    i_dtwm_host_model.stop;
  endtask
  // an all-unknown expected byte means do not compare
  task rd(input logic [7:0] a, input logic [7:0] q[$]);
    wr(a, '{});
    i_dtwm_host_model.start;
    send(8'hA1);
    foreach (q[i]) begin
      i_dtwm_host_model.rbyte(i == q.size() - 1, lastByte);
      if (q[i] !== 8'hXX) chk_byte("read data", q[i], lastByte);
    end
    i_dtwm_host_model.stop;
  endtask
  // ==========================================
  // scenarios
  task t_rate;
    chk_bit("rate mode", 1'b0, fcMode);
    wr(8'h75, '{8'hFF});
    chk_bit("rate mode", 1'b1, fcMode);
    rd(8'h75, '{8'hFF});
    wr(8'h75, '{8'hFE});
    chk_bit("rate mode", 1'b0, fcMode);
    rd(8'h75, '{8'hFE});
    wr(8'h75, '{8'h01});
    sys_rst <= 1'b1;
    repeat (2) @(posedge mclk);
    sys_rst <= 1'b0;
    repeat (6) @(posedge mclk);
    chk_bit("rate mode", 1'b0, fcMode);
  endtask
  task t_wrap;
    wr(8'hFF, '{8'h11, 8'h5A});
    rd(8'hFF, '{8'h11, 8'h00});
  endtask
  task t_monitor;
    monAll <= 80'hA1B2_C3D4_E5F6_0718_293A;
    rd(8'h60, '{8'hA1, 8'hB2});
    rd(8'h64, '{8'hC3, 8'hD4, 8'hE5, 8'hF6, 8'h07, 8'h18, 8'h29, 8'h3A});
  endtask
  task t_flags;
    rd(8'h50, '{8'h00, 8'h00, 8'h00});
    limAll <= 20'hFFFFF;
    rd(8'h50, '{8'h1F});
    chk_bit("alarm flags", 1'b1, |lastByte);
    rd(8'h52, '{8'h1F});
    chk_bit("warn flags", 1'b1, |lastByte);
  endtask
  task t_refuse;
    logic a;
    i_dtwm_host_model.start;
    i_dtwm_host_model.wbyte(8'hB0, a);
    chk_bit("ack", 1'b0, a);
    chk_bit("busy", 1'b0, busy);
    i_dtwm_host_model.stop;
    wr(8'h10, '{8'h3C});
    rd(8'h10, '{8'h00});
    chk_bit("busy", 1'b0, busy);
  endtask
  // ==========================================
  // sequence, watchdog and verdict
  initial begin
    repeat (10) @(posedge mclk);
    sys_rst <= 1'b0;
    repeat (6) @(posedge mclk);
    t_rate;
    t_wrap;
    t_monitor;
    t_flags;
    t_refuse;
    tally_and_finish;
  end
  initial begin
    repeat (60000) @(posedge mclk);
    err_total++;
    tally_and_finish;
  end
  task tally_and_finish;
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
endmodule // dtwm_slave_bench
